// >>> pkg/rpit_defs.vh
// Register indices, field positions, reset values and timing counts of the periodic timer
`ifndef RPIT_DEFS_VH
`define RPIT_DEFS_VH

// Register indices; the byte address on the bus is four times the index
`define RPIT_IDX_CMP_LO 6'h0a
`define RPIT_IDX_CMP_HI 6'h0b
`define RPIT_IDX_CTRL 6'h10
`define RPIT_IDX_SYNC_STATUS 6'h11
`define RPIT_IDX_IRQ_CONTROL 6'h12
`define RPIT_IDX_IRQ_FLAGS 6'h13
`define RPIT_IDX_DBG_CONTROL 6'h15

// Timer control fields
`define RPIT_CTRL_ON_BIT 0
`define RPIT_CTRL_PERIOD_LSB 3
`define RPIT_CTRL_PERIOD_MSB 6
`define RPIT_CTRL_WMASK 8'h79

// Status, flag, enable and debug fields
`define RPIT_SYNC_PENDING_BIT 0
`define RPIT_IRQ_BIT 0
`define RPIT_DBG_RUN_BIT 0

// Reset values
`define RPIT_CTRL_RESET 8'h00
`define RPIT_STATUS_RESET 8'h00
`define RPIT_CMP_RESET 16'h0000
`define RPIT_CMP_BYTE_RESET 8'h00
`define RPIT_IRQ_CONTROL_RESET 1'b0

// Period codes
`define RPIT_PERIOD_OFF 4'h0
`define RPIT_PERIOD_MAX 4'he

// Timing
`define RPIT_PRESCALE_WIDTH 15
`define RPIT_RTC_SYNC_STAGES 2

`endif

// >>> src/rpit_edge_sync.v
// Two-flop synchroniser for the slow RTC clock with rising-edge detection
`timescale 1ns/10ps
module rpit_edge_sync
(
    input wire pclk,      // System clock
    input wire presetn,   // Asynchronous reset, active low
    input wire async_in,  // Level from outside the pclk domain
    output wire rise      // One-cycle pulse per rising edge of async_in
);

reg meta_ff;
reg sync_ff;
reg last_ff;

////////////////////////////////////////////////////////////////////////////////
// The first stage feeds only the second; the edge is taken after it
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        meta_ff <= 1'b0;
        sync_ff <= 1'b0;
        last_ff <= 1'b0;
    end
    else
    begin
        meta_ff <= async_in;
        sync_ff <= meta_ff;
        last_ff <= sync_ff;
    end
end

assign rise = sync_ff & ~last_ff;

endmodule

// >>> src/rpit_prescaler.v
// Free-running prescaler counting RTC clock cycles while the timer runs
`timescale 1ns/10ps
module rpit_prescaler
#(
    parameter WIDTH = 15  // Counter width, covers the longest interval
)
(
    input wire pclk,               // System clock
    input wire presetn,            // Asynchronous reset, active low
    input wire clear,              // Synchronous clear, wins over tick
    input wire tick,               // One RTC cycle has elapsed
    output wire [WIDTH-1:0] count  // Current count
);

reg [WIDTH-1:0] count_ff;
reg [WIDTH-1:0] nxt_count;

////////////////////////////////////////////////////////////////////////////////
always @*
begin
    nxt_count = count_ff;
    if (clear)
        nxt_count = {WIDTH{1'b0}};
    else if (tick)
        nxt_count = count_ff + {{(WIDTH-1){1'b0}}, 1'b1};
end

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
        count_ff <= {WIDTH{1'b0}};
    else
        count_ff <= nxt_count;
end

assign count = count_ff;

endmodule

// >>> src/rpit_top.v
// Periodic interrupt timer with compare value, reached over APB
//
// Overview of operation
// RQ1: Compare high byte bits 15:8, RW, resets zero
// RQ2: Compare low byte bits 7:0, separately accessible
// RQ3: Period field bits 6:3 selects interval
// RQ4: Code 0 off, 1..E give 4..32768, F reserved
// RQ5: Control bit 0 enables the periodic timer
// RQ6: Status bit 0 high while control syncs
// RQ7: Control and status reset 0x00; status read-only
// RQ8: Flag set per interrupt, cleared writing one
// RQ9: Enable bit gates flag onto interrupt request
// RQ10: Software waits for sync idle before rewriting
//
// Register map, byte address four times the index:
// 0x0a compare low byte, 0x0b compare high byte
// 0x10 timer control: bit 0 on, bits 6:3 period
// 0x11 sync status: bit 0 control pending, read-only
// 0x12 interrupt enable, 0x13 interrupt flag (write one clears)
// 0x15 debug control: bit 0 keeps counting under a halt
// Unmapped or misaligned accesses answer with pslverr
`timescale 1ns/10ps
`include "rpit_defs.vh"
module rpit_top
#(
    parameter ADDR_WIDTH = 8,                  // APB byte address width
    parameter PRESCALE_WIDTH = `RPIT_PRESCALE_WIDTH  // Interval counter width
)
(
    input wire pclk,                    // System clock, 20 MHz
    input wire presetn,                 // Asynchronous reset, active low
    input wire psel,                    // APB select
    input wire penable,                 // APB access phase
    input wire pwrite,                  // APB direction, high for write
    input wire [ADDR_WIDTH-1:0] paddr,  // APB byte address
    input wire [31:0] pwdata,           // APB write data
    output wire [31:0] prdata,          // APB read data
    output wire pready,                 // APB ready
    output wire pslverr,                // APB error on unmapped address
    input wire rtc_clk,                 // Slow RTC clock from the oscillator
    input wire debug_halt,              // CPU halted by the debugger, pclk domain
    output wire [15:0] compare_value,   // Compare value for the counter
    output wire irq                     // Interrupt request, level
);

////////////////////////////////////////////////////////////////////////////////
// Declarations

reg [7:0] cmp_lo_ff;
reg [7:0] cmp_hi_ff;
reg [7:0] ctrl_ff;
reg [7:0] rtc_ctrl_ff;
reg control_sync_pending_ff;
reg periodic_irq_flag_ff;
reg periodic_irq_enable_ff;
reg dbg_run_ff;
reg [31:0] prdata_ff;
reg pslverr_ff;
reg [31:0] nxt_prdata;
reg nxt_pslverr;
reg nxt_flag;
reg nxt_pending;

wire [5:0] reg_idx;
wire setup_phase;
wire access_phase;
wire wr_en;
wire addr_hit;
wire rtc_rise;
wire [PRESCALE_WIDTH-1:0] pre_count;
wire [3:0] live_period;
wire live_on;
wire halted;
wire run_tick;
wire pre_clear;
wire fire;
wire ctrl_wr;
wire flag_clr;

////////////////////////////////////////////////////////////////////////////////
// Functions

// True when the index names a register of this block
function is_mapped;
    input [5:0] idx;
    begin
        case (idx)
            `RPIT_IDX_CMP_LO,
            `RPIT_IDX_CMP_HI,
            `RPIT_IDX_CTRL,
            `RPIT_IDX_SYNC_STATUS,
            `RPIT_IDX_IRQ_CONTROL,
            `RPIT_IDX_IRQ_FLAGS,
            `RPIT_IDX_DBG_CONTROL:
                is_mapped = 1'b1;
            default:
                is_mapped = 1'b0;
        endcase
    end
endfunction

// Interval end: code k counts 2^(k+1) RTC cycles, so the low k+1 bits are all ones
function interval_done;
    input [3:0] code;
    input [PRESCALE_WIDTH-1:0] cnt;
    reg [PRESCALE_WIDTH-1:0] mask;
    begin
        mask = {PRESCALE_WIDTH{1'b0}};
        interval_done = 1'b0;
        if (code != `RPIT_PERIOD_OFF && code <= `RPIT_PERIOD_MAX) // RQ4
        begin
            mask = ~({PRESCALE_WIDTH{1'b1}} << (code + 4'h1));
            interval_done = ((cnt & mask) == mask);
        end
    end
endfunction

// True for a completing write to the given register index
function reg_write;
    input en;
    input [5:0] idx;
    input [5:0] target;
    begin
        reg_write = en && (idx == target);
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// APB decode; zero wait states, every access completes in its access phase

// Byte lanes are unused: each register takes the low byte of one aligned word
assign reg_idx = paddr[7:2];
assign setup_phase = psel & ~penable;
assign access_phase = psel & penable;
assign addr_hit = is_mapped(reg_idx) && (paddr[1:0] == 2'b00);
assign wr_en = access_phase & pwrite & addr_hit;
assign pready = 1'b1;
assign pslverr = pslverr_ff & access_phase;
assign prdata = prdata_ff;

// Read data is captured in the setup phase so it stands registered in the access phase
always @*
begin
    nxt_prdata = prdata_ff;
    nxt_pslverr = pslverr_ff;
    if (setup_phase)
    begin
        nxt_pslverr = ~addr_hit;
        nxt_prdata = 32'h0000_0000;
        if (!pwrite && addr_hit)
        begin
            case (reg_idx)
                `RPIT_IDX_CMP_LO: nxt_prdata[7:0] = cmp_lo_ff; // RQ2
                `RPIT_IDX_CMP_HI: nxt_prdata[7:0] = cmp_hi_ff; // RQ1
                `RPIT_IDX_CTRL: nxt_prdata[7:0] = ctrl_ff;
                `RPIT_IDX_SYNC_STATUS:
                    nxt_prdata[`RPIT_SYNC_PENDING_BIT] = control_sync_pending_ff; // RQ6
                `RPIT_IDX_IRQ_CONTROL:
                    nxt_prdata[`RPIT_IRQ_BIT] = periodic_irq_enable_ff;
                `RPIT_IDX_IRQ_FLAGS:
                    nxt_prdata[`RPIT_IRQ_BIT] = periodic_irq_flag_ff;
                `RPIT_IDX_DBG_CONTROL:
                    nxt_prdata[`RPIT_DBG_RUN_BIT] = dbg_run_ff;
                default: nxt_prdata = 32'h0000_0000;
            endcase
        end
    end
end

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        prdata_ff <= 32'h0000_0000;
        pslverr_ff <= 1'b0;
    end
    else
    begin
        prdata_ff <= nxt_prdata;
        pslverr_ff <= nxt_pslverr;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Write strobes

// Both strobes meet hardware events in the same cycle, so they are named once here
assign ctrl_wr = reg_write(wr_en, reg_idx, `RPIT_IDX_CTRL);
assign flag_clr = reg_write(wr_en, reg_idx, `RPIT_IDX_IRQ_FLAGS) & pwdata[`RPIT_IRQ_BIT];

////////////////////////////////////////////////////////////////////////////////
// Software registers

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        cmp_lo_ff <= `RPIT_CMP_BYTE_RESET; // RQ2
        cmp_hi_ff <= `RPIT_CMP_BYTE_RESET; // RQ1
        ctrl_ff <= `RPIT_CTRL_RESET; // RQ7
        periodic_irq_enable_ff <= `RPIT_IRQ_CONTROL_RESET; // RQ9
        dbg_run_ff <= 1'b0;
    end
    else if (wr_en)
    begin
        case (reg_idx)
            `RPIT_IDX_CMP_LO: cmp_lo_ff <= pwdata[7:0]; // RQ2
            `RPIT_IDX_CMP_HI: cmp_hi_ff <= pwdata[7:0]; // RQ1
            // Reserved bits 7, 2 and 1 stay zero
            `RPIT_IDX_CTRL: ctrl_ff <= pwdata[7:0] & `RPIT_CTRL_WMASK; // RQ3 RQ5
            `RPIT_IDX_IRQ_CONTROL:
                periodic_irq_enable_ff <= pwdata[`RPIT_IRQ_BIT]; // RQ9
            `RPIT_IDX_DBG_CONTROL: dbg_run_ff <= pwdata[`RPIT_DBG_RUN_BIT];
            default: dbg_run_ff <= dbg_run_ff;
        endcase
    end
end

assign compare_value = {cmp_hi_ff, cmp_lo_ff}; // RQ1 RQ2

////////////////////////////////////////////////////////////////////////////////
// Control transfer into the RTC cycle domain

rpit_edge_sync u_rtc_sync
(
    .pclk(pclk),
    .presetn(presetn),
    .async_in(rtc_clk),
    .rise(rtc_rise)
);

// A write marks the control value pending; the next RTC edge adopts it.
// A second write while pending simply replaces the value not yet adopted.
always @*
begin
    nxt_pending = control_sync_pending_ff;
    if (rtc_rise)
        nxt_pending = 1'b0;
    if (ctrl_wr)
        nxt_pending = 1'b1; // RQ6
end

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        control_sync_pending_ff <= 1'b0; // RQ7
        rtc_ctrl_ff <= `RPIT_CTRL_RESET;
    end
    else
    begin
        control_sync_pending_ff <= nxt_pending; // RQ6
        // The adopting tick is still ruled by the old setting, so it is not counted when the timer was off before
        if (rtc_rise && control_sync_pending_ff)
            rtc_ctrl_ff <= ctrl_ff;
    end
end

assign live_on = rtc_ctrl_ff[`RPIT_CTRL_ON_BIT]; // RQ5
assign live_period = rtc_ctrl_ff[`RPIT_CTRL_PERIOD_MSB:`RPIT_CTRL_PERIOD_LSB]; // RQ3

////////////////////////////////////////////////////////////////////////////////
// Interval counting

// Under a debug halt the timer freezes unless debug run is set
assign halted = debug_halt & ~dbg_run_ff;
assign run_tick = rtc_rise & live_on & ~halted;
// Disabling clears the count, so re-enabling starts a whole interval
assign pre_clear = ~live_on; // RQ5

rpit_prescaler #(.WIDTH(PRESCALE_WIDTH)) u_prescaler
(
    .pclk(pclk),
    .presetn(presetn),
    .clear(pre_clear),
    .tick(run_tick),
    .count(pre_count)
);

assign fire = run_tick & interval_done(live_period, pre_count); // RQ3 RQ4

////////////////////////////////////////////////////////////////////////////////
// Interrupt flag and request

// A new interrupt in the cycle of a write-one clear keeps the flag set
always @*
begin
    nxt_flag = periodic_irq_flag_ff;
    if (flag_clr)
        nxt_flag = 1'b0; // RQ8
    if (fire)
        nxt_flag = 1'b1; // RQ8
end

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
        periodic_irq_flag_ff <= 1'b0;
    else
        periodic_irq_flag_ff <= nxt_flag;
end

assign irq = periodic_irq_flag_ff & periodic_irq_enable_ff; // RQ9

endmodule

// >>> testbench/rpit_monitor.sv
// Concurrent checks on the ports of the periodic timer
`timescale 1ns/10ps
module rpit_monitor
#(
    parameter ADDR_WIDTH = 8,
    parameter PRESCALE_WIDTH = 15
)
(
    input wire pclk, // Clock
    input wire presetn, // Reset
    input wire psel, // Select
    input wire penable, // Access
    input wire pwrite, // Write
    input wire [ADDR_WIDTH-1:0] paddr, // Address
    input wire [31:0] pwdata, // Wdata
    input wire [31:0] prdata, // Rdata
    input wire pready, // Ready
    input wire pslverr, // Error
    input wire rtc_clk, // RTC clock
    input wire debug_halt, // Halt
    input wire [15:0] compare_value, // Compare
    input wire irq // Interrupt
);
////////////////////////////////////////
wire wr_acc = psel && penable && pwrite;
wire rd_acc = psel && penable && !pwrite;
wire irq_wr = wr_acc && (paddr == 8'h4c || paddr == 8'h48);
reg irq_en_ff;
// Shadow of the interrupt enable, updated at the same edge as the design's
always @(posedge pclk or negedge presetn)
    if (!presetn)
        irq_en_ff <= 1'b0;
    else if (wr_acc && paddr == 8'h48)
        irq_en_ff <= pwdata[0];
default clocking @(posedge pclk); endclocking
default disable iff (!presetn);
////////////////////////////////////////
cmp_hi_wr_a: assert property (wr_acc && paddr == 8'h2c |=> compare_value[15:8] == $past(pwdata[7:0]))
    else $error("compare high byte not written");
cmp_lo_wr_a: assert property (wr_acc && paddr == 8'h28 |=>
    compare_value[7:0] == $past(pwdata[7:0]) && $stable(compare_value[15:8]))
    else $error("compare low byte not written alone");
cmp_hi_rd_a: assert property (rd_acc && paddr == 8'h2c |-> prdata == {24'h0, compare_value[15:8]})
    else $error("compare high byte read wrong");
cmp_lo_rd_a: assert property (rd_acc && paddr == 8'h28 |-> prdata == {24'h0, compare_value[7:0]})
    else $error("compare low byte read wrong");
ctrl_rsvd_a: assert property (rd_acc && paddr == 8'h40 |-> (prdata & 32'hffffff86) == 32'h0)
    else $error("control read outside its fields");
status_rd_a: assert property (rd_acc && paddr == 8'h44 |-> prdata[31:1] == 31'h0)
    else $error("status read outside busy bit");
irq_gate_a: assert property (irq |-> irq_en_ff)
    else $error("interrupt while disabled");
irq_off_a: assert property (wr_acc && paddr == 8'h48 && !pwdata[0] |=> !irq)
    else $error("interrupt stays after disable");
irq_fall_a: assert property ($fell(irq) |-> $past(irq_wr))
    else $error("interrupt dropped without a write");
cover property ($rose(irq));
cover property (rd_acc && paddr == 8'h44 && prdata[0]);
cover property (pslverr);
endmodule

bind rpit_top rpit_monitor #(.ADDR_WIDTH(ADDR_WIDTH), .PRESCALE_WIDTH(PRESCALE_WIDTH)) i_rpit_monitor
(
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rtc_clk(rtc_clk), .debug_halt(debug_halt), .compare_value(compare_value), .irq(irq)
);

// >>> testbench/rpit_top_bench.sv
// Self-checking bench for the periodic timer
`timescale 1ns/10ps
module rpit_top_bench;
logic pclk, presetn, psel, penable, pwrite, rtc_clk, debug_halt, pready, pslverr, irq, er;
logic [7:0] paddr;
logic [31:0] pwdata, prdata, rd;
logic [15:0] compare_value;
logic [7:0] regs [6] = '{8'h28, 8'h2c, 8'h40, 8'h44, 8'h48, 8'h4c};
logic [31:0] ctrl_vals [3] = '{32'hff, 32'h01, 32'h08};
integer fails, samples_checked, i;
rpit_top i_rpit_top
(
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rtc_clk(rtc_clk), .debug_halt(debug_halt), .compare_value(compare_value), .irq(irq)
);
////////////////////////////////////////
task conclude;
    begin
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    end
endtask
task chk(input [31:0] g, input [31:0] e);
    begin
        samples_checked = samples_checked + 1;
        if (g !== e)
        begin
            fails = fails + 1;
            $display("[FAIL] %0t got %h expected %h", $time, g, e);
        end
    end
endtask
// Bus transfer; waits for pready under a bound
task apb(input w, input [7:0] a, input [31:0] d);
    integer n;
    begin
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin @(posedge pclk); n = n + 1; end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1)
        begin
            fails = fails + 1;
            $display("[FAIL] %0t bus timeout", $time);
            conclude;
        end
        else
        begin
            rd = prdata; er = pslverr; psel <= 1'b0; penable <= 1'b0;
            @(posedge pclk);
        end
    end
endtask
// Slow clock runs only while stimulus asks for ticks
task ticks(input integer n);
    integer k;
    for (k = 0; k < n; k = k + 1)
    begin
        rtc_clk <= 1'b1; repeat (4) @(posedge pclk);
        rtc_clk <= 1'b0; repeat (4) @(posedge pclk);
    end
endtask
// Polls the pending bit, letting RTC cycles pass, before control is rewritten
task sync_idle;
    integer n;
    begin
        n = 0;
        apb(0, 8'h44, 0);
        while (rd[0] !== 1'b0 && n < 8)
        begin
            ticks(1); apb(0, 8'h44, 0); n = n + 1;
        end
        chk(rd, 32'h0);
        if (rd[0] !== 1'b0)
            conclude;
    end
endtask
////////////////////////////////////////
task t_basic;
    begin
        for (i = 0; i < 6; i = i + 1) begin apb(0, regs[i], 0); chk(rd, 32'h0); end
        apb(1, 8'h2c, 32'ha5); apb(1, 8'h28, 32'h3c);
        chk({16'h0, compare_value}, 32'ha53c);
        apb(1, 8'h28, 32'h5a); apb(0, 8'h2c, 0);
        chk(rd, 32'ha5);
        chk({16'h0, compare_value}, 32'ha55a);
        apb(0, 8'h7c, 0); chk({31'h0, er}, 32'h1);
        apb(1, 8'h44, 32'hff); apb(0, 8'h44, 0); chk(rd, 32'h0);
        $display("test basic done");
    end
endtask
task t_ctrl;
    begin
        apb(1, 8'h48, 32'h1);
        for (i = 0; i < 3; i = i + 1)
        begin
            sync_idle;
            apb(1, 8'h40, ctrl_vals[i]); ticks(1);
            apb(0, 8'h40, 0); chk(rd, ctrl_vals[i] & 32'h79);
            ticks(16); chk({31'h0, irq}, 32'h0);
        end
        $display("test control done");
    end
endtask
task t_period(input [3:0] code);
    integer p;
    begin
        p = 1 << (code + 1);
        sync_idle;
        apb(1, 8'h40, {25'h0, code, 3'b001});
        apb(0, 8'h44, 0); chk(rd, 32'h1);
        ticks(1);
        apb(0, 8'h44, 0); chk(rd, 32'h0);
        ticks(p - 1); chk({31'h0, irq}, 32'h0);
        ticks(1); chk({31'h0, irq}, 32'h1);
        apb(1, 8'h4c, 32'h1); chk({31'h0, irq}, 32'h0);
        apb(1, 8'h40, 0); ticks(1);
        $display("test period %0d done", code);
    end
endtask
task t_mask;
    begin
        apb(1, 8'h48, 0); sync_idle;
        apb(1, 8'h40, 32'h09); ticks(5);
        chk({31'h0, irq}, 32'h0);
        apb(0, 8'h4c, 0); chk(rd, 32'h1);
        apb(1, 8'h48, 32'h1); chk({31'h0, irq}, 32'h1);
        apb(1, 8'h4c, 32'h1); apb(0, 8'h4c, 0); chk(rd, 32'h0);
        apb(1, 8'h40, 0); ticks(1);
        $display("test mask done");
    end
endtask
// A debug halt freezes counting until debug run is set
task t_debug;
    begin
        debug_halt <= 1'b1;
        sync_idle;
        apb(1, 8'h40, 32'h09); ticks(5);
        chk({31'h0, irq}, 32'h0);
        apb(1, 8'h54, 32'h1); apb(0, 8'h54, 0); chk(rd, 32'h1);
        ticks(4); chk({31'h0, irq}, 32'h1);
        apb(1, 8'h4c, 32'h1); apb(1, 8'h40, 0); ticks(1);
        debug_halt <= 1'b0;
        $display("test debug done");
    end
endtask
////////////////////////////////////////
initial
begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
end
initial
begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
    pwdata = 32'h0; rtc_clk = 1'b0; debug_halt = 1'b0; fails = 0; samples_checked = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_basic; t_ctrl; t_period(4'h1); t_period(4'h2); t_period(4'h3); t_mask; t_debug;
    conclude;
end
endmodule
